// ===== adc_seq_pkg.sv
package adc_seq_pkg;

  // ==========================================================
  // Widths.
  localparam int RES_W = 12;
  localparam int DIV_W = 7;
  localparam int PH_W  = 4;

  // ==========================================================
  // Conversion timing in converter clock periods.
  localparam logic [PH_W-1:0] SAMPLE_TICKS = 4'h4;
  localparam logic [PH_W-1:0] CONV_TICKS   = 4'hC;
  localparam logic [PH_W-1:0] PH_RST       = 4'h0;
  localparam logic [PH_W-1:0] PH_ONE       = 4'h1;

  // ==========================================================
  // Reset values and codes.
  localparam logic [RES_W-1:0] RES_RST    = 12'h000;
  localparam logic [RES_W-1:0] MSB_MASK   = 12'h800;
  localparam logic [RES_W-1:0] FULL_SCALE = 12'hFFF;
  localparam logic [DIV_W-1:0] DIV_RST    = 7'h00;
  localparam logic [DIV_W-1:0] DIV_ONE    = 7'h01;
  localparam logic [3:0]       SRC_EXT    = 4'h0;
  localparam logic [3:0]       NIB_ZERO   = 4'h0;
  localparam logic             FMT_LEFT   = 1'b0;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_DONE
  } seq_state_e;

endpackage

// ===== adc_conversion_sequencer.sv
`timescale 1ns/1ps
// Function
// - Sampling lasts 4 converter clocks, then conversion lasts 12 converter clocks.
// - Once launched, conversion runs on its own without software help.
// - Software pulses start low-high-low after configuring; device converts on it.
// - Start going high resets the converter; start returning low launches conversion.
// - Busy flag stays high throughout a conversion in progress.
// - Busy flag returns low when the conversion finishes.
// - Finished result is readable in the high and low result bytes.
// - With power enable low the converter circuitry is off.
// - Internal source disconnects the external channel regardless of channel select.
// - Format select arranges the result across the two result bytes.
// - Result is 12 bits; FFF means input equals the reference.
// - Completion sets the interrupt request flag and raises enabled interrupt.
// - Converter clock is system clock divided by two to the select value.
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             start_i,
  input  wire logic             converter_power_enable_i,
  input  wire logic [2:0]       clock_divider_select_i,
  input  wire logic [3:0]       input_source_select_i,
  input  wire logic [3:0]       external_channel_select_i,
  input  wire logic [1:0]       reference_select_i,
  input  wire logic             result_format_select_i,
  input  wire logic             global_interrupt_enable_i,
  input  wire logic             converter_interrupt_enable_i,
  input  wire logic             irq_clear_i,
  input  wire logic             compare_i,
  output logic                  analog_power_o,
  output logic                  sample_o,
  output logic                  ext_connect_o,
  output logic [3:0]            channel_o,
  output logic [3:0]            source_o,
  output logic [1:0]            reference_o,
  output logic [RES_W-1:0]      dac_code_o,
  output logic                  conversion_busy_flag_o,
  output logic [7:0]            result_high_byte_o,
  output logic [7:0]            result_low_byte_o,
  output logic                  converter_interrupt_request_o,
  output logic                  irq_o
);

  // ==========================================================
  // Start edge detection.
  logic             start_q;
  logic             start_rise;
  logic             launch;
  seq_state_e       state_q;
  logic [PH_W-1:0]  phase_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_mask;
  logic             tick;
  logic [RES_W-1:0] trial_q;
  logic [RES_W-1:0] bit_q;
  logic [RES_W-1:0] kept;
  logic [RES_W-1:0] result_q;
  logic             busy_q;
  logic             flag_q;

  // Previous start level, for edge detection.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_i;
    end
  end

  // Rising edge resets; falling edge launches, but only when powered.
  assign start_rise = start_i && !start_q;
  assign launch     = !start_i && start_q && converter_power_enable_i;

  // ==========================================================
  // Converter clock divider.
  // Mask of low counter bits; a tick fires when they are all ones.
  assign div_mask = DIV_W'((DIV_ONE << clock_divider_select_i) - DIV_ONE);
  assign tick     = (div_q & div_mask) == div_mask;

  // Free counter, realigned at launch so sampling gets full periods.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= DIV_RST;
    end else if (launch || !converter_power_enable_i) begin
      div_q <= DIV_RST;
    end else begin
      div_q <= div_q + DIV_ONE;
    end
  end

  // ==========================================================
  // Sequencer state and phase counter.
  // Abort on power loss or start rise has priority over progress.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      phase_q <= PH_RST;
    end else if (!converter_power_enable_i || start_rise) begin
      state_q <= ST_IDLE;
      phase_q <= PH_RST;
    end else if (launch) begin
      state_q <= ST_SAMPLE;
      phase_q <= PH_RST;
    end else begin
      case (state_q)
        ST_SAMPLE: begin
          if (tick) begin
            if (phase_q == SAMPLE_TICKS - PH_ONE) begin
              state_q <= ST_CONVERT;
              phase_q <= PH_RST;
            end else begin
              phase_q <= phase_q + PH_ONE;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            if (phase_q == CONV_TICKS - PH_ONE) begin
              state_q <= ST_DONE;
              phase_q <= PH_RST;
            end else begin
              phase_q <= phase_q + PH_ONE;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Successive approximation register.
  // A trial bit is kept when the input is at or above the trial code.
  assign kept = compare_i ? trial_q : (trial_q & ~bit_q);

  // One decision per converter clock, MSB first, twelve in all.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trial_q <= RES_RST;
      bit_q   <= RES_RST;
    end else if (launch) begin
      trial_q <= MSB_MASK;
      bit_q   <= MSB_MASK;
    end else if (state_q == ST_CONVERT && tick) begin
      bit_q   <= bit_q >> 1;
      trial_q <= kept | (bit_q >> 1);
    end
  end

  // ==========================================================
  // Result capture; held until the next completion.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_q <= RES_RST;
    end else if (state_q == ST_CONVERT && tick && phase_q == CONV_TICKS - PH_ONE
                 && !start_rise && converter_power_enable_i) begin
      result_q <= kept;
    end
  end

  // Byte arrangement chosen by the format select.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_high_byte_o <= RES_RST[7:0];
      result_low_byte_o  <= RES_RST[7:0];
    end else if (result_format_select_i == FMT_LEFT) begin
      result_high_byte_o <= result_q[11:4];
      result_low_byte_o  <= {result_q[3:0], NIB_ZERO};
    end else begin
      result_high_byte_o <= {NIB_ZERO, result_q[11:8]};
      result_low_byte_o  <= result_q[7:0];
    end
  end

  // ==========================================================
  // Busy flag and interrupt request.
  // Busy rises on launch, falls one cycle after the result is stored.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
    end else if (!converter_power_enable_i || start_rise) begin
      busy_q <= 1'b0;
    end else if (launch) begin
      busy_q <= 1'b1;
    end else if (state_q == ST_DONE) begin
      busy_q <= 1'b0;
    end
  end

  // Completion sets the request; a set beats a same-cycle clear.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q <= 1'b0;
    end else if (state_q == ST_DONE && converter_power_enable_i && !start_rise) begin
      flag_q <= 1'b1;
    end else if (irq_clear_i) begin
      flag_q <= 1'b0;
    end
  end

  assign conversion_busy_flag_o        = busy_q;
  assign converter_interrupt_request_o = flag_q;
  assign irq_o = flag_q && global_interrupt_enable_i && converter_interrupt_enable_i;

  // ==========================================================
  // Analog front-end controls, registered.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      analog_power_o <= 1'b0;
      sample_o       <= 1'b0;
      ext_connect_o  <= 1'b0;
      channel_o      <= NIB_ZERO;
      source_o       <= NIB_ZERO;
      reference_o    <= 2'h0;
    end else begin
      analog_power_o <= converter_power_enable_i;
      sample_o       <= converter_power_enable_i && state_q == ST_SAMPLE;
      ext_connect_o  <= converter_power_enable_i
                        && input_source_select_i == SRC_EXT;
      channel_o      <= external_channel_select_i;
      source_o       <= input_source_select_i;
      reference_o    <= reference_select_i;
    end
  end

  // The trial register drives the comparator directly, so each decision sees the current trial.
  assign dac_code_o = trial_q;

  // ==========================================================
  // Checks.
  logic [4:0] tick_cnt_q;

  // Converter clocks seen since launch.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt_q <= 5'h00;
    end else if (launch) begin
      tick_cnt_q <= 5'h00;
    end else if (tick && (state_q == ST_SAMPLE || state_q == ST_CONVERT)) begin
      tick_cnt_q <= tick_cnt_q + 5'h01;
    end
  end

  sequence s_launch;
    !start_i && $past(start_i) && converter_power_enable_i;
  endsequence

  sequence s_finish;
    state_q == ST_DONE && converter_power_enable_i && !start_rise;
  endsequence

  property p_total_ticks;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_finish |-> tick_cnt_q == 5'h10;
  endproperty
  a_total_ticks: assert property (p_total_ticks) else $error("Wrong tick count.");

  property p_sample_len;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == ST_CONVERT && $past(state_q) == ST_SAMPLE |-> tick_cnt_q == 5'h04 && sample_o;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("Wrong sample length.");

  property p_launch_busy;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_launch |=> conversion_busy_flag_o ##1 sample_o;
  endproperty
  a_launch_busy: assert property (p_launch_busy) else $error("Launch missed.");

  property p_rise_abort;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      start_i && !$past(start_i) |=> !conversion_busy_flag_o && state_q == ST_IDLE;
  endproperty
  a_rise_abort: assert property (p_rise_abort) else $error("Abort missed.");

  property p_busy_until_done;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(conversion_busy_flag_o) && $past(converter_power_enable_i) && !$past(start_rise)
        |-> $past(state_q) == ST_DONE;
  endproperty
  a_busy_until_done: assert property (p_busy_until_done) else $error("Busy fell early.");

  property p_done_clears;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_finish |=> !conversion_busy_flag_o && converter_interrupt_request_o;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("Finish not flagged.");

  property p_result_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $changed(result_q) |-> $past(state_q) == ST_CONVERT && state_q == ST_DONE;
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("Result moved.");

  property p_power_off;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !converter_power_enable_i |=> !analog_power_o && !conversion_busy_flag_o;
  endproperty
  a_power_off: assert property (p_power_off) else $error("Power not off.");

  property p_internal_src;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      input_source_select_i != SRC_EXT |=> !ext_connect_o;
  endproperty
  a_internal_src: assert property (p_internal_src) else $error("External left on.");

  property p_irq_out;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      converter_interrupt_request_o && global_interrupt_enable_i
        && converter_interrupt_enable_i |-> irq_o;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("Interrupt missing.");

endmodule

// ===== tb_adc_conversion_sequencer.sv
`timescale 1ns/1ps
module tb_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  // ==========================================================
  // Stimulus, observed outputs and bookkeeping.
  logic             clk, nrst, start, pwr, fmt, gie, cie, irq_clr, cmp;
  logic [2:0]       div_sel;
  logic [3:0]       src_sel, ch_sel, chan, src;
  logic [1:0]       ref_sel, refo;
  logic [RES_W-1:0] dac, target;
  logic [7:0]       hi, lo;
  logic             apwr, smp, ext, busy, req, irq;
  int               errors, total_checks;

  // Ideal comparator: keeps a trial bit while the trial does not exceed the input.
  assign cmp = (dac <= target) ? 1'b1 : 1'b0;

  adc_conversion_sequencer adc_conversion_sequencer_inst (
    .sys_clk_i(clk), .nrst_i(nrst), .start_i(start), .converter_power_enable_i(pwr),
    .clock_divider_select_i(div_sel), .input_source_select_i(src_sel),
    .external_channel_select_i(ch_sel), .reference_select_i(ref_sel),
    .result_format_select_i(fmt), .global_interrupt_enable_i(gie),
    .converter_interrupt_enable_i(cie), .irq_clear_i(irq_clr), .compare_i(cmp),
    .analog_power_o(apwr), .sample_o(smp), .ext_connect_o(ext), .channel_o(chan),
    .source_o(src), .reference_o(refo), .dac_code_o(dac),
    .conversion_busy_flag_o(busy), .result_high_byte_o(hi), .result_low_byte_o(lo),
    .converter_interrupt_request_o(req), .irq_o(irq));

  // The 125 MHz system clock.
  always #4 clk = ~clk;

  // ==========================================================
  // Comparison, reporting and shared drivers.
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_len(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Expected result bytes for a code in the chosen layout.
  task automatic check_res(input logic [RES_W-1:0] t);
    logic [15:0] exp;
    exp = fmt ? {4'h0, t} : {t, 4'h0};
    check_val({hi, lo}, exp);
  endtask

  // Low-high-low on start, then measure how long busy stands.
  task automatic run_conv(input logic [2:0] sel, output int len);
    int n;
    n   = 0;
    len = 0;
    @(posedge clk) div_sel <= sel;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    #1;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (busy === 1'b1 && len < 5000) begin
      @(posedge clk);
      #1;
      len++;
    end
  endtask

  // ==========================================================
  // Scenarios.
  task automatic t_reset();
    check_val({busy, req, irq, apwr, ext}, 16'h0000);
    check_res(RES_RST);
    @(posedge clk) pwr <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check_val({apwr, ext}, 16'h0003);
  endtask

  task automatic t_routing();
    @(posedge clk) ch_sel <= 4'h9;
    ref_sel <= 2'h2;
    src_sel <= 4'h5;
    repeat (3) @(posedge clk);
    #1;
    check_val({chan, src, 2'h0, refo, 3'h0, ext}, 16'h9520);
    @(posedge clk) src_sel <= SRC_EXT;
    repeat (3) @(posedge clk);
    #1;
    check_val({3'h0, ext}, 16'h0001);
  endtask

  task automatic t_divider();
    int len;
    target = 12'hA5C;
    @(posedge clk) fmt <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      run_conv(s[2:0], len);
      check_len(len, 16 * (1 << s) + 1);
      check_val({busy, req}, 16'h0001);
      check_res(12'hA5C);
    end
  endtask

  task automatic t_format();
    int len;
    target = FULL_SCALE;
    @(posedge clk) fmt <= 1'b0;
    run_conv(3'h0, len);
    check_res(FULL_SCALE);
    target = 12'h3B7;
    run_conv(3'h1, len);
    check_res(12'h3B7);
  endtask

  task automatic t_abort();
    int len;
    target = 12'h61E;
    run_conv(3'h2, len);
    target = 12'h0D4;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check_val({3'h0, smp}, 16'h0001);
    repeat (17) @(posedge clk);
    start <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_val({3'h0, busy}, 16'h0000);
    check_res(12'h61E);
    run_conv(3'h0, len);
    check_len(len, 17);
    check_res(12'h0D4);
  endtask

  task automatic t_power();
    @(posedge clk) pwr <= 1'b0;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check_val({busy, apwr, ext}, 16'h0000);
    check_res(12'h0D4);
    @(posedge clk) pwr <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic t_irq();
    int len;
    @(posedge clk) irq_clr <= 1'b1;
    @(posedge clk) irq_clr <= 1'b0;
    gie <= 1'b1;
    cie <= 1'b1;
    #1;
    check_val({req, irq}, 16'h0000);
    run_conv(3'h0, len);
    check_val({req, irq}, 16'h0003);
    @(posedge clk) gie <= 1'b0;
    @(posedge clk);
    #1;
    check_val({req, irq}, 16'h0002);
    @(posedge clk) irq_clr <= 1'b1;
    gie <= 1'b1;
    @(posedge clk) irq_clr <= 1'b0;
    @(posedge clk);
    #1;
    check_val({req, irq}, 16'h0000);
  endtask

  // ==========================================================
  // Main sequence: reset for 16 cycles, then the scenarios.
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    start = 1'b0;
    pwr = 1'b0;
    fmt = 1'b0;
    gie = 1'b0;
    cie = 1'b0;
    irq_clr = 1'b0;
    div_sel = 3'h0;
    src_sel = SRC_EXT;
    ch_sel = 4'h0;
    ref_sel = 2'h0;
    target = 12'h000;
    errors = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_routing();
    t_divider();
    t_format();
    t_abort();
    t_power();
    t_irq();
    complete_run();
  end

  // Watchdog well beyond the roughly 4400 cycles the scenarios need.
  initial begin
    #(8 * 40000);
    errors++;
    complete_run();
  end
endmodule
